// ### src/ldh_consts.svh
`ifndef LDH_CONSTS_SVH
`define LDH_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define LDH_CLK_MHZ     200
`define LDH_PHASE_NS    400
`define LDH_INIT_NS     1000
// ----------------------------------------
// bus layout and drive patterns
// ----------------------------------------
`define LDH_SCL_BIT     6
`define LDH_SI_BIT      7
`define LDH_LAST_BIT    3'h7
`define LDH_OE_ALL      8'hff
`define LDH_OE_NONE     8'h00
`define LDH_OE_SERIAL   8'hc0
`define LDH_BYTE_ZERO   8'h00
`define LDH_PULL_LEVEL  8'hff
`endif

// ### src/ldh_pkg.sv
`default_nettype none
package ldh_pkg;
	typedef logic [7:0] ldh_byte_t;

	// host transfer sequencer, gray along idle-setup-strobe-hold
	typedef enum logic [1:0] {
		LDH_IDLE   = 2'b00,
		LDH_SETUP  = 2'b01,
		LDH_STROBE = 2'b11,
		LDH_HOLD   = 2'b10
	} ldh_state_e;

	// device pin levels as seen after synchronising
	typedef struct packed {
		logic      parallelSelect;
		logic      busStyleSelect;
		logic      internalDividerSelect;
		logic      chipSelectLowActiveN;
		logic      chipSelectHighActive;
		logic      dataCommandSelect;
		logic      readPin;
		logic      writePin;
		ldh_byte_t busLines;
		logic      masterSelect;
		logic      lcAlternationIn;
		logic      blankingControlInN;
	} ldh_pins_s;
endpackage
`default_nettype wire

// ### src/ldh_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldh_consts.svh"
interface ldh_link_if;
	import ldh_pkg::*;
	// straps
	logic      busStyleSelect;
	logic      parallelSelect;
	logic      internalDividerSelect;
	// control pins
	logic      chipSelectLowActiveN;
	logic      chipSelectHighActive;
	logic      initLowN;
	logic      dataCommandSelect;
	logic      readPin;
	logic      writePin;
	// bus lines, one enable per line on each side
	ldh_byte_t hostBusOut;
	ldh_byte_t hostBusOe;
	ldh_byte_t devBusOut;
	ldh_byte_t devBusOe;
	ldh_byte_t busLines;

	// undriven lines read as pulled high
	assign busLines = (devBusOe & devBusOut) | (hostBusOe & ~devBusOe & hostBusOut)
		| (~devBusOe & ~hostBusOe & `LDH_PULL_LEVEL);

	modport dev (
		input  busStyleSelect, parallelSelect, internalDividerSelect,
		input  chipSelectLowActiveN, chipSelectHighActive, initLowN,
		input  dataCommandSelect, readPin, writePin, busLines,
		output devBusOut, devBusOe
	);
	modport host (
		output busStyleSelect, parallelSelect, internalDividerSelect,
		output chipSelectLowActiveN, chipSelectHighActive, initLowN,
		output dataCommandSelect, readPin, writePin, hostBusOut, hostBusOe,
		input  busLines
	);
endinterface
`default_nettype wire

// ### src/ldh_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// ### src/ldh_dev_end.sv
// Operation
// - strap picks enable-strobe or separate-strobe style
// - strap picks parallel byte or serial input
// - serial data on line 7, clock line 6
// - serial mode leaves lines 0-5 undriven
// - host holds both strobes fixed in serial
// - no read-back in serial mode
// - divider strap enables internal divider resistors
// - selected only when both chip selects active
// - all lines undriven while not selected
// - init low returns settings to initial state
// - select high means display data, low command
// - separate style: write taken on strobe rise
// - enable style: write pin high read, low write
// - separate style: drive bus while read low
// - enable style: read pin is active-high enable
// - eight-bit bidirectional parallel data path
// - slave takes alternation signal from master
// - master drives alternation and blanking outward
// - slave takes blanking control from master
// - master and slave share one display clock
`timescale 1ns/1ps
`default_nettype none
`include "ldh_consts.svh"
module ldh_dev_end (
	// clock and reset
	input  wire logic            displayClockIn,
	input  wire logic            nrst,
	// link
	ldh_link_if.dev              link,
	// master/slave pins
	input  wire logic            masterSelect,
	input  wire logic            lcAlternationIn,
	output logic                 lcAlternationOut,
	output logic                 lcAlternationOe,
	input  wire logic            blankingControlInN,
	output logic                 blankingControlOutN,
	output logic                 blankingControlOe,
	// own display timing
	input  wire logic            alternationGen,
	input  wire logic            blankingGenN,
	output logic                 alternationSeen,
	output logic                 blankingSeenN,
	// received bytes
	output logic                 rxValid,
	output ldh_pkg::ldh_byte_t   rxByte,
	output logic                 rxIsData,
	// read-back
	input  wire ldh_pkg::ldh_byte_t rdByte,
	output logic                 rdTaken,
	// settings
	output logic                 dividerUse
);
	import ldh_pkg::*;

	// ----------------------------------------
	// reset: asserts at once, releases on the display clock
	// ----------------------------------------
	logic      rawRstN;
	logic      rstStage_reg;
	logic      rstN;

	assign rawRstN = nrst & link.initLowN;

	always_ff @(posedge displayClockIn or negedge rawRstN) begin
		if (!rawRstN) begin
			rstStage_reg <= 1'b0;
			rstN         <= 1'b0;
		end else begin
			rstStage_reg <= 1'b1;
			rstN         <= rstStage_reg;
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	ldh_pins_s pinRaw;
	ldh_pins_s pinSync;
	ldh_pins_s pin_reg;

	assign pinRaw.parallelSelect        = link.parallelSelect;
	assign pinRaw.busStyleSelect        = link.busStyleSelect;
	assign pinRaw.internalDividerSelect = link.internalDividerSelect;
	assign pinRaw.chipSelectLowActiveN  = link.chipSelectLowActiveN;
	assign pinRaw.chipSelectHighActive  = link.chipSelectHighActive;
	assign pinRaw.dataCommandSelect     = link.dataCommandSelect;
	assign pinRaw.readPin               = link.readPin;
	assign pinRaw.writePin              = link.writePin;
	assign pinRaw.busLines              = link.busLines;
	assign pinRaw.masterSelect          = masterSelect;
	assign pinRaw.lcAlternationIn       = lcAlternationIn;
	assign pinRaw.blankingControlInN    = blankingControlInN;

	ldh_sync #(
		.WIDTH ($bits(ldh_pins_s))
	) pinSyncInst (
		.clk     (displayClockIn),
		.nrst    (rstN),
		.asyncIn (pinRaw),
		.syncOut (pinSync)
	);

	// previous synchronised levels, for edge detection
	logic [2:0] warm_reg;
	logic       pinLive;

	// edges count only once pin_reg holds a real synchronised level
	assign pinLive = warm_reg[2];

	always_ff @(posedge displayClockIn or negedge rstN) begin
		if (!rstN) begin
			pin_reg  <= '0;
			warm_reg <= 3'h0;
		end else begin
			pin_reg  <= pinSync;
			warm_reg <= {warm_reg[1:0], 1'b1};
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic      selected;
	logic      parMode;
	logic      enStyle;
	logic      sepWrite;
	logic      enWrite;
	logic      sepRead;
	logic      enRead;
	logic      readNow;
	logic      readStart;
	logic      sclkRise;
	logic      serialDone;
	ldh_byte_t shiftNext;
	logic [2:0] bitCnt_reg;
	logic [2:0] bitCnt_next;
	ldh_byte_t shift_reg;

	assign selected  = ~pinSync.chipSelectLowActiveN & pinSync.chipSelectHighActive;
	assign parMode   = pinSync.parallelSelect;
	assign enStyle   = pinSync.busStyleSelect;

	// separate style: write latched when the write strobe rises
	assign sepWrite  = parMode & ~enStyle & selected & ~pin_reg.writePin & pinSync.writePin & pinLive;
	// enable style: write when enable falls with the direction low
	assign enWrite   = parMode & enStyle & selected & pin_reg.readPin & ~pinSync.readPin
		& ~pinSync.writePin & pinLive;
	assign sepRead   = parMode & ~enStyle & selected & ~pinSync.readPin;
	assign enRead    = parMode & enStyle & selected & pinSync.readPin & pinSync.writePin;
	// serial mode never reaches either read term
	assign readNow   = sepRead | enRead;
	assign readStart = readNow & ~(|link.devBusOe);

	// serial: data on line 7, shift clock on line 6, write only
	assign sclkRise   = ~parMode & selected & ~pin_reg.busLines[`LDH_SCL_BIT]
		& pinSync.busLines[`LDH_SCL_BIT] & pinLive;
	assign shiftNext  = {shift_reg[6:0], pinSync.busLines[`LDH_SI_BIT]};
	assign serialDone = sclkRise & (bitCnt_reg == `LDH_LAST_BIT);
	assign bitCnt_next = !(selected & ~parMode) ? 3'h0 : sclkRise ? bitCnt_reg + 3'h1 : bitCnt_reg;

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	always_ff @(posedge displayClockIn or negedge rstN) begin
		if (!rstN) begin
			bitCnt_reg <= 3'h0;
			shift_reg  <= `LDH_BYTE_ZERO;
		end else begin
			bitCnt_reg <= bitCnt_next;
			shift_reg  <= sclkRise ? shiftNext : shift_reg;
		end
	end

	// ----------------------------------------
	// received bytes
	// ----------------------------------------
	logic      rxValid_next;
	ldh_byte_t rxByte_next;
	logic      rxIsData_next;

	assign rxValid_next  = sepWrite | enWrite | serialDone;
	assign rxByte_next   = serialDone ? shiftNext : pinSync.busLines;
	assign rxIsData_next = pinSync.dataCommandSelect;

	always_ff @(posedge displayClockIn or negedge rstN) begin
		if (!rstN) begin
			rxValid  <= 1'b0;
			rxByte   <= `LDH_BYTE_ZERO;
			rxIsData <= 1'b0;
		end else begin
			rxValid  <= rxValid_next;
			rxByte   <= rxValid_next ? rxByte_next : rxByte;
			rxIsData <= rxValid_next ? rxIsData_next : rxIsData;
		end
	end

	// ----------------------------------------
	// bus drive
	// ----------------------------------------
	ldh_byte_t busOe_next;

	// undriven unless a parallel read is under way; serial drives nothing
	assign busOe_next = readNow ? `LDH_OE_ALL : `LDH_OE_NONE;

	always_ff @(posedge displayClockIn or negedge rstN) begin
		if (!rstN) begin
			link.devBusOe  <= `LDH_OE_NONE;
			link.devBusOut <= `LDH_BYTE_ZERO;
			rdTaken        <= 1'b0;
		end else begin
			link.devBusOe  <= busOe_next;
			link.devBusOut <= readStart ? rdByte : link.devBusOut;
			rdTaken        <= readStart;
		end
	end

	// ----------------------------------------
	// settings and master/slave pins
	// ----------------------------------------
	logic      altOut_next;
	logic      blankOut_next;

	assign altOut_next   = alternationGen;
	assign blankOut_next = blankingGenN;

	assign lcAlternationOe   = pinSync.masterSelect;
	assign blankingControlOe = pinSync.masterSelect;
	// shared display clock makes master levels usable directly
	assign alternationSeen = pinSync.masterSelect ? lcAlternationOut
		: pinSync.lcAlternationIn;
	assign blankingSeenN   = pinSync.masterSelect ? blankingControlOutN
		: pinSync.blankingControlInN;

	always_ff @(posedge displayClockIn or negedge rstN) begin
		if (!rstN) begin
			lcAlternationOut    <= 1'b0;
			blankingControlOutN <= 1'b0;
			dividerUse          <= 1'b0;
		end else begin
			lcAlternationOut    <= altOut_next;
			blankingControlOutN <= blankOut_next;
			dividerUse          <= pinSync.internalDividerSelect;
		end
	end
endmodule
`default_nettype wire

// ### src/ldh_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldh_consts.svh"
module ldh_host_end #(
	parameter int PHASE_CYC = (`LDH_PHASE_NS * `LDH_CLK_MHZ + 999) / 1000,
	parameter int INIT_CYC  = (`LDH_INIT_NS * `LDH_CLK_MHZ + 999) / 1000
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// link
	ldh_link_if.host                link,
	// straps
	input  wire logic               busStyleSel,
	input  wire logic               parallelSel,
	input  wire logic               dividerSel,
	// device init
	input  wire logic               devInitReq,
	// commands
	input  wire logic               cmdValid,
	output logic                    cmdReady,
	input  wire logic               cmdRead,
	input  wire logic               cmdIsData,
	input  wire ldh_pkg::ldh_byte_t cmdByte,
	// answers
	output logic                    respValid,
	output ldh_pkg::ldh_byte_t      respByte
);
	import ldh_pkg::*;

	localparam int CW = 16;

	// ----------------------------------------
	// state
	// ----------------------------------------
	ldh_state_e    state_reg;
	ldh_state_e    state_next;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [2:0]    bits_reg;
	logic [2:0]    bits_next;
	ldh_byte_t     data_reg;
	ldh_byte_t     data_next;
	logic          read_reg;
	logic          read_next;
	ldh_byte_t     busSync;
	logic          serial;
	logic          enStyle;
	logic          idleRd;
	logic          phaseEnd;
	logic          take;
	logic          moreBits;

	ldh_sync #(
		.WIDTH (8)
	) busSyncInst (
		.clk     (clk),
		.nrst    (nrst),
		.asyncIn (link.busLines),
		.syncOut (busSync)
	);

	assign serial   = ~link.parallelSelect;
	assign enStyle  = link.busStyleSelect & link.parallelSelect;
	// strobe rest levels; both fixed high in serial mode
	assign idleRd   = ~enStyle;
	assign phaseEnd = (cnt_reg == '0);
	assign cmdReady = (state_reg == LDH_IDLE) & link.initLowN;
	assign take     = cmdValid & cmdReady;
	assign moreBits = serial & (bits_reg != `LDH_LAST_BIT);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next   = phaseEnd ? CW'(PHASE_CYC - 1) : cnt_reg - 1'b1;
		bits_next  = bits_reg;
		data_next  = data_reg;
		read_next  = read_reg;
		case (state_reg)
			LDH_IDLE: begin
				cnt_next  = CW'(PHASE_CYC - 1);
				bits_next = 3'h0;
				data_next = cmdByte;
				read_next = cmdRead;
				// serial reads are taken and dropped
				if (take && !(serial && cmdRead)) begin
					state_next = LDH_SETUP;
				end
			end
			LDH_SETUP: begin
				if (phaseEnd) begin
					state_next = LDH_STROBE;
				end
			end
			LDH_STROBE: begin
				if (phaseEnd) begin
					if (moreBits) begin
						state_next = LDH_SETUP;
						bits_next  = bits_reg + 3'h1;
						data_next  = {data_reg[6:0], 1'b0};
					end else begin
						state_next = LDH_HOLD;
					end
				end
			end
			LDH_HOLD: begin
				if (phaseEnd) begin
					state_next = LDH_IDLE;
				end
			end
			default: begin
				state_next = LDH_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// pin levels
	// ----------------------------------------
	logic      active;
	logic      strobe;
	logic      rd_next;
	logic      wr_next;
	ldh_byte_t out_next;
	ldh_byte_t oe_next;
	logic      [CW-1:0] init_next;
	logic      [CW-1:0] init_reg;

	assign active  = (state_next != LDH_IDLE);
	assign strobe  = (state_next == LDH_STROBE);
	assign rd_next = serial ? 1'b1 : enStyle ? strobe : ~(strobe & read_next);
	assign wr_next = serial ? 1'b1 : enStyle ? read_next : ~(strobe & ~read_next);
	// serial: data on line 7, shift clock on line 6, others left alone
	assign out_next = serial ? {data_next[7], strobe, 6'h00} : data_next;
	assign oe_next  = !active ? `LDH_OE_NONE : serial ? `LDH_OE_SERIAL
		: read_next ? `LDH_OE_NONE : `LDH_OE_ALL;
	assign init_next = devInitReq ? '0 : (init_reg == CW'(INIT_CYC)) ? init_reg : init_reg + 1'b1;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= LDH_IDLE;
			cnt_reg   <= '0;
			bits_reg  <= 3'h0;
			data_reg  <= `LDH_BYTE_ZERO;
			read_reg  <= 1'b0;
			init_reg  <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			bits_reg  <= bits_next;
			data_reg  <= data_next;
			read_reg  <= read_next;
			init_reg  <= init_next;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.busStyleSelect        <= 1'b0;
			link.parallelSelect        <= 1'b1;
			link.internalDividerSelect <= 1'b0;
			link.initLowN              <= 1'b0;
			link.chipSelectLowActiveN  <= 1'b1;
			link.chipSelectHighActive  <= 1'b0;
			link.dataCommandSelect     <= 1'b0;
			link.readPin               <= 1'b1;
			link.writePin              <= 1'b1;
			link.hostBusOut            <= `LDH_BYTE_ZERO;
			link.hostBusOe             <= `LDH_OE_NONE;
			respValid                  <= 1'b0;
			respByte                   <= `LDH_BYTE_ZERO;
		end else begin
			// style and parallel straps follow the user inputs only between transfers; the divider strap follows dividerSel at all times
			link.busStyleSelect        <= active ? link.busStyleSelect : busStyleSel;
			link.parallelSelect        <= active ? link.parallelSelect : parallelSel;
			link.internalDividerSelect <= dividerSel;
			link.initLowN              <= (init_next == CW'(INIT_CYC));
			link.chipSelectLowActiveN  <= ~active;
			link.chipSelectHighActive  <= active;
			link.dataCommandSelect     <= take ? cmdIsData : link.dataCommandSelect;
			link.readPin               <= active ? rd_next : idleRd;
			link.writePin              <= active ? wr_next : 1'b1;
			link.hostBusOut            <= out_next;
			link.hostBusOe             <= oe_next;
			respValid                  <= (state_reg == LDH_STROBE) & phaseEnd & read_reg & ~serial;
			respByte                   <= ((state_reg == LDH_STROBE) & phaseEnd & read_reg) ? busSync : respByte;
		end
	end
endmodule
`default_nettype wire

// ### verification/lcd_driver_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_link_sva
	import ldh_pkg::*;
(
	// clock and reset
	input wire logic      displayClockIn,
	input wire logic      nrst,
	// link pins
	input wire logic      busStyleSelect,
	input wire logic      parallelSelect,
	input wire logic      chipSelectLowActiveN,
	input wire logic      chipSelectHighActive,
	input wire logic      initLowN,
	input wire logic      readPin,
	input wire logic      writePin,
	input wire ldh_byte_t hostBusOe,
	input wire ldh_byte_t devBusOe
);
	// --------------------------------
	// decode
	// --------------------------------
	wire logic selected;
	wire logic readCond;
	assign selected = !chipSelectLowActiveN && chipSelectHighActive;
	assign readCond = selected && parallelSelect && (busStyleSelect ? (readPin && writePin) : !readPin);

	default clocking cb @(posedge displayClockIn);
	endclocking
	default disable iff (!nrst);

	// --------------------------------
	// sequences
	// --------------------------------
	sequence readHeld;
		readCond [*4];
	endsequence
	sequence readOff;
		(!readCond) [*6];
	endsequence
	sequence serialHeld;
		(!parallelSelect) [*6];
	endsequence

	// --------------------------------
	// assertions
	// --------------------------------
	a_read_drive: assert property (readHeld |-> devBusOe == 8'hff)
		else $error("bus not driven during a held read");
	a_idle_release: assert property (readOff |-> devBusOe == 8'h00)
		else $error("bus driven with no read requested");
	a_unselect_free: assert property ((!selected) [*6] |-> devBusOe == 8'h00)
		else $error("bus driven while not selected");
	a_serial_low_free: assert property (serialHeld |-> devBusOe[5:0] == 6'h00)
		else $error("lines 0 to 5 driven in serial mode");
	a_serial_no_read: assert property (serialHeld |-> devBusOe[7:6] == 2'h0)
		else $error("serial lines driven by device");
	a_init_quiet: assert property (!initLowN |-> devBusOe == 8'h00)
		else $error("bus driven while init held low");
	a_strobe_fixed: assert property ((!parallelSelect) [*3] |-> $stable(readPin) && $stable(writePin))
		else $error("strobes moved in serial mode");
	a_no_contend: assert property ((hostBusOe & devBusOe) == 8'h00)
		else $error("both ends drive the bus");
	a_serial_rd_high: assert property ((!parallelSelect) [*3] |-> readPin && writePin)
		else $error("strobes not held high in serial mode");
endmodule
`default_nettype wire

// ### verification/test_lcd_driver_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_lcd_driver_host_port;
	import ldh_pkg::*;
	localparam int LIMIT = 80000;
	logic      clk, displayClockIn, nrst;
	logic      busStyleSel, parallelSel, dividerSel, devInitReq;
	logic      cmdValid, cmdReady, cmdRead, cmdIsData, respValid;
	ldh_byte_t cmdByte, respByte, rxByte, rdByte;
	logic      masterSelect, lcAlternationIn, lcAlternationOut, lcAlternationOe;
	logic      blankingControlInN, blankingControlOutN, blankingControlOe;
	logic      alternationGen, blankingGenN, alternationSeen, blankingSeenN;
	logic      rxValid, rxIsData, rdTaken, dividerUse, seenResp;
	int        error_cnt, n_checks, cycles;

	ldh_link_if link();
	ldh_host_end #(.PHASE_CYC(80), .INIT_CYC(4)) u_ldh_host_end (.clk(clk), .nrst(nrst), .link(link),
		.busStyleSel(busStyleSel), .parallelSel(parallelSel), .dividerSel(dividerSel), .devInitReq(devInitReq),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdIsData(cmdIsData), .cmdByte(cmdByte),
		.respValid(respValid), .respByte(respByte));
	ldh_dev_end u_ldh_dev_end (.displayClockIn(displayClockIn), .nrst(nrst), .link(link),
		.masterSelect(masterSelect), .lcAlternationIn(lcAlternationIn), .lcAlternationOut(lcAlternationOut),
		.lcAlternationOe(lcAlternationOe), .blankingControlInN(blankingControlInN),
		.blankingControlOutN(blankingControlOutN), .blankingControlOe(blankingControlOe),
		.alternationGen(alternationGen), .blankingGenN(blankingGenN), .alternationSeen(alternationSeen),
		.blankingSeenN(blankingSeenN), .rxValid(rxValid), .rxByte(rxByte), .rxIsData(rxIsData),
		.rdByte(rdByte), .rdTaken(rdTaken), .dividerUse(dividerUse));
	ldh_link_sva u_ldh_link_sva (.displayClockIn(displayClockIn), .nrst(nrst),
		.busStyleSelect(link.busStyleSelect), .parallelSelect(link.parallelSelect),
		.chipSelectLowActiveN(link.chipSelectLowActiveN), .chipSelectHighActive(link.chipSelectHighActive),
		.initLowN(link.initLowN), .readPin(link.readPin), .writePin(link.writePin),
		.hostBusOe(link.hostBusOe), .devBusOe(link.devBusOe));

	// --------------------------------
	// clocks and timeout
	// --------------------------------
	always #2.5 clk = ~clk;
	// single display clock fed to every display end
	initial begin
		displayClockIn = 1'b0;
		#13;
		forever #40 displayClockIn = ~displayClockIn;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			error_cnt++;
			end_of_test();
		end
	end

	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic exp_seen(input logic master, input logic own, input logic pin);
		return master ? own : pin;
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic send(input logic rd, input logic isData, input ldh_byte_t b);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmdValid = 1'b1;
		cmdRead = rd;
		cmdIsData = isData;
		cmdByte = b;
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
	endtask

	task automatic wr_check(input logic isData, input ldh_byte_t b);
		int n;
		send(1'b0, isData, b);
		n = 0;
		while (rxValid !== 1'b1 && n < 200) begin
			@(posedge displayClockIn);
			#1;
			n++;
		end
		check("rxValid", {7'h0, rxValid}, 8'h01);
		check("rxByte", rxByte, b);
		check("rxIsData", {7'h0, rxIsData}, {7'h0, isData});
		repeat (100) @(posedge clk);
		#1;
	endtask

	task automatic rd_check(input ldh_byte_t b);
		int n;
		rdByte = b;
		send(1'b1, 1'b0, 8'h00);
		n = 0;
		while (rdTaken !== 1'b1 && n < 20) begin
			@(posedge displayClockIn);
			#1;
			n++;
		end
		check("rdTaken", {7'h0, rdTaken}, 8'h01);
		n = 0;
		while (respValid !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("respValid", {7'h0, respValid}, 8'h01);
		check("respByte", respByte, b);
		repeat (100) @(posedge clk);
		#1;
	endtask

	task automatic set_mode(input logic style, input logic par);
		send(1'b0, 1'b0, 8'h00);
		repeat (400) @(posedge clk);
		#1;
		busStyleSel = style;
		parallelSel = par;
		repeat (200) @(posedge clk);
		#1;
	endtask

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{busStyleSel, dividerSel, devInitReq, cmdValid, cmdRead, cmdIsData} = '0;
		parallelSel = 1'b1;
		{masterSelect, lcAlternationIn, alternationGen} = '0;
		{blankingControlInN, blankingGenN} = '1;
		cmdByte = 8'h00;
		rdByte = 8'h00;
		seenResp = 1'b0;
		void'($urandom(32'hfa23));
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		dividerSel = 1'b1;
		repeat (200) @(posedge clk);
		#1;
		check("dividerUse", {7'h0, dividerUse}, 8'h01);
		devInitReq = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check("dividerUse in init", {7'h0, dividerUse}, 8'h00);
		devInitReq = 1'b0;
		dividerSel = 1'b0;
		repeat (200) @(posedge clk);
		#1;
		check("dividerUse off", {7'h0, dividerUse}, 8'h00);
		for (int s = 0; s < 2; s++) begin
			set_mode(s[0], 1'b1);
			wr_check(1'b0, 8'h00);
			wr_check(1'b1, 8'hff);
			repeat (5) wr_check(1'($urandom), 8'($urandom));
			rd_check(8'h00);
			rd_check(8'hff);
			repeat (2) rd_check(8'($urandom));
		end
		set_mode(1'b0, 1'b0);
		wr_check(1'b1, 8'h80);
		wr_check(1'b0, 8'h01);
		repeat (4) wr_check(1'($urandom), 8'($urandom));
		send(1'b1, 1'b0, 8'h00);
		repeat (2000) begin
			@(posedge clk);
			#1;
			seenResp = seenResp | (respValid === 1'b1);
		end
		check("respValid serial", {7'h0, seenResp}, 8'h00);
		for (int m = 0; m < 2; m++) begin
			masterSelect = m[0];
			repeat (4) begin
				alternationGen = 1'($urandom);
				blankingGenN = 1'($urandom);
				lcAlternationIn = 1'($urandom);
				blankingControlInN = 1'($urandom);
				repeat (6) @(posedge displayClockIn);
				#1;
				check("lcAlternationOe", {7'h0, lcAlternationOe}, {7'h0, m[0]});
				check("blankingControlOe", {7'h0, blankingControlOe}, {7'h0, m[0]});
				if (m == 1) begin
					check("lcAlternationOut", {7'h0, lcAlternationOut}, {7'h0, alternationGen});
					check("blankingControlOutN", {7'h0, blankingControlOutN}, {7'h0, blankingGenN});
				end
				check("alternationSeen", {7'h0, alternationSeen},
					{7'h0, exp_seen(m[0], alternationGen, lcAlternationIn)});
				check("blankingSeenN", {7'h0, blankingSeenN},
					{7'h0, exp_seen(m[0], blankingGenN, blankingControlInN)});
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
